/* src/udcb_pkg.sv */
// package for the up/down event counter bank: register map, layouts and reset values
// Notes on behaviour
// - count only on rising edges of inputs
// - eight identical independent counters
// - disabled counter ignores everything
// - preset is full-range signed 32-bit
// - three exclusive compare flags: above, equal, below
// - up edge adds one, wraps max to min
// - down edge subtracts one, wraps min to max
// - block input freezes counting and control
// - on enable load preset or zero
// - rising select loads preset while running
// - reset loads preset or zero by select
// - freeze-reset captures count, stamp, then loads preset or zero by select
// - freeze-count captures count, stamp, keeps counting
// - count, frozen count, stamp readable
// - save counts to storage on power loss
package udcb_pkg;
    localparam int unsigned UDCB_NUM_COUNTERS = 8;
    localparam int unsigned UDCB_ADDR_W = 8;
    localparam int unsigned UDCB_STAMP_W = 64;
    // per-counter register window: index is counter*16 + offset, byte address is 4x
    localparam logic [3:0] UDCB_REG_CTRL = 4'h0;
    localparam logic [3:0] UDCB_REG_PRESET = 4'h1;
    localparam logic [3:0] UDCB_REG_COMPARE = 4'h2;
    localparam logic [3:0] UDCB_REG_COUNT = 4'h3;
    localparam logic [3:0] UDCB_REG_FROZEN = 4'h4;
    localparam logic [3:0] UDCB_REG_STAMP_LO = 4'h5;
    localparam logic [3:0] UDCB_REG_STAMP_HI = 4'h6;
    localparam logic [3:0] UDCB_REG_FLAGS = 4'h7;
    // ctrl field positions
    localparam int unsigned UDCB_CTRL_ENABLE_BIT = 0;
    // flags field positions
    localparam int unsigned UDCB_FLAG_ABOVE_BIT = 0;
    localparam int unsigned UDCB_FLAG_EQUAL_BIT = 1;
    localparam int unsigned UDCB_FLAG_BELOW_BIT = 2;
    // reset values
    localparam logic [31:0] UDCB_PRESET_RST = 32'h0000_0000;
    localparam logic [31:0] UDCB_COMPARE_RST = 32'h0000_0000;
    localparam logic [31:0] UDCB_COUNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] UDCB_RDATA_UNMAPPED = 32'h0000_0000;

    // operand inputs of one counter
    typedef struct packed {
        logic up;
        logic down;
        logic block;
        logic load_value_select;
        logic reset;
        logic freeze_reset;
        logic freeze_count;
    } udcb_ops_t;

    // compare flags of one counter
    typedef struct packed {
        logic count_below_compare;
        logic count_equals_compare;
        logic count_above_compare;
    } udcb_flags_t;
endpackage

/* src/udcb_bank.sv */
// bank of signed 32-bit up/down event counters with freeze, preset and compare
`timescale 1ns/1ps
`default_nettype none
module udcb_bank
    import udcb_pkg::*;
#(
    parameter int unsigned N = UDCB_NUM_COUNTERS
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [UDCB_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // counter operands from other logic
    input wire udcb_ops_t ops [N],
    // date/time stamp source
    input wire logic [UDCB_STAMP_W-1:0] time_stamp,
    // power loss save handshake
    input wire logic power_fail,
    output logic save_valid,
    output logic [$clog2(N)-1:0] save_index,
    output logic [31:0] save_count,
    output logic [31:0] save_frozen,
    output logic save_done,
    // compare flags
    output udcb_flags_t flags [N]
);
    localparam int unsigned IW = $clog2(N);

    logic en_ff [N];
    logic [31:0] preset_ff [N];
    logic [31:0] compare_ff [N];
    logic [31:0] count_ff [N];
    logic [31:0] frozen_ff [N];
    logic [UDCB_STAMP_W-1:0] stamp_ff [N];
    udcb_ops_t ops_s1_ff [N];
    udcb_ops_t ops_s2_ff [N];
    udcb_ops_t ops_prev_ff [N];
    logic en_prev_ff [N];

    // register address split into counter number and offset
    logic [3:0] reg_off;
    logic [UDCB_ADDR_W-5:0] reg_cnt;
    assign reg_off = reg_addr[3:0];
    assign reg_cnt = reg_addr[UDCB_ADDR_W-1:4];

    // signed three-way compare, used for flags and kept in one place
    function automatic udcb_flags_t cmp3(input logic [31:0] a, input logic [31:0] b);
        udcb_flags_t f;
        f.count_above_compare = $signed(a) > $signed(b);
        f.count_equals_compare = a == b;
        f.count_below_compare = $signed(a) < $signed(b);
        return f;
    endfunction

    // operand synchronisers: operands may come from slower logic, keep two stages
    always_ff @(posedge clk or posedge reset) begin
        for (int i = 0; i < N; i++) begin
            if (reset) begin
                ops_s1_ff[i] <= '0;
                ops_s2_ff[i] <= '0;
                ops_prev_ff[i] <= '0;
            end else begin
                ops_s1_ff[i] <= ops[i];
                ops_s2_ff[i] <= ops_s1_ff[i];
                ops_prev_ff[i] <= ops_s2_ff[i];
            end
        end
    end

    // software settings, one window per counter
    always_ff @(posedge clk or posedge reset) begin
        for (int i = 0; i < N; i++) begin
            if (reset) begin
                en_ff[i] <= 1'b0;
                preset_ff[i] <= UDCB_PRESET_RST;
                compare_ff[i] <= UDCB_COMPARE_RST;
            end else if (reg_wr && reg_cnt == (UDCB_ADDR_W-4)'(i)) begin
                unique case (reg_off)
                    UDCB_REG_CTRL: en_ff[i] <= reg_wdata[UDCB_CTRL_ENABLE_BIT];
                    UDCB_REG_PRESET: preset_ff[i] <= reg_wdata;
                    UDCB_REG_COMPARE: compare_ff[i] <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // enable history for the load-on-enable
    always_ff @(posedge clk or posedge reset) begin
        for (int i = 0; i < N; i++) begin
            if (reset) begin
                en_prev_ff[i] <= 1'b0;
            end else begin
                en_prev_ff[i] <= en_ff[i];
            end
        end
    end

    // counting core; loads win over edges, capture reads the pre-load count
    always_ff @(posedge clk or posedge reset) begin
        for (int i = 0; i < N; i++) begin
            if (reset) begin
                count_ff[i] <= UDCB_COUNT_ZERO;
                frozen_ff[i] <= UDCB_COUNT_ZERO;
                stamp_ff[i] <= '0;
            end else begin
                automatic udcb_ops_t cur = ops_s2_ff[i];
                automatic udcb_ops_t old = ops_prev_ff[i];
                automatic logic [31:0] load_val;
                automatic logic up_e;
                automatic logic dn_e;
                load_val = cur.load_value_select ? preset_ff[i] : UDCB_COUNT_ZERO;
                up_e = cur.up && !old.up;
                dn_e = cur.down && !old.down;
                if (en_ff[i] && !en_prev_ff[i]) begin
                    count_ff[i] <= load_val;
                end else if (!en_ff[i] || cur.block) begin
                    // hold: disabled or blocked
                end else begin
                    if ((cur.freeze_reset && !old.freeze_reset)
                        || (cur.freeze_count && !old.freeze_count)) begin
                        frozen_ff[i] <= count_ff[i];
                        stamp_ff[i] <= time_stamp;
                    end
                    if (cur.freeze_reset && !old.freeze_reset) begin
                        count_ff[i] <= load_val;
                    end else if (cur.reset && !old.reset) begin
                        count_ff[i] <= load_val;
                    end else if (cur.load_value_select && !old.load_value_select) begin
                        count_ff[i] <= preset_ff[i];
                    end else if (up_e && !dn_e) begin
                        count_ff[i] <= count_ff[i] + 32'h0000_0001;
                    end else if (dn_e && !up_e) begin
                        count_ff[i] <= count_ff[i] - 32'h0000_0001;
                    end // both edges cancel
                end
            end
        end
    end

    // compare flags registered from the running count
    always_ff @(posedge clk or posedge reset) begin
        for (int i = 0; i < N; i++) begin
            if (reset) begin
                flags[i] <= '0;
            end else begin
                flags[i] <= cmp3(count_ff[i], compare_ff[i]);
            end
        end
    end

    // register read, data in the next cycle only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= UDCB_RDATA_UNMAPPED;
        end else if (reg_rd && reg_cnt < (UDCB_ADDR_W-4)'(N)) begin
            unique case (reg_off)
                UDCB_REG_CTRL: reg_rdata <= {31'h0, en_ff[reg_cnt[IW-1:0]]};
                UDCB_REG_PRESET: reg_rdata <= preset_ff[reg_cnt[IW-1:0]];
                UDCB_REG_COMPARE: reg_rdata <= compare_ff[reg_cnt[IW-1:0]];
                UDCB_REG_COUNT: reg_rdata <= count_ff[reg_cnt[IW-1:0]];
                UDCB_REG_FROZEN: reg_rdata <= frozen_ff[reg_cnt[IW-1:0]];
                UDCB_REG_STAMP_LO: reg_rdata <= stamp_ff[reg_cnt[IW-1:0]][31:0];
                UDCB_REG_STAMP_HI: reg_rdata <= stamp_ff[reg_cnt[IW-1:0]][63:32];
                UDCB_REG_FLAGS: reg_rdata <= {29'h0, flags[reg_cnt[IW-1:0]]};
                default: reg_rdata <= UDCB_RDATA_UNMAPPED;
            endcase
        end else begin
            reg_rdata <= UDCB_RDATA_UNMAPPED;
        end
    end

    // power-fail save walk: one counter per cycle, level-sensitive power_fail
    logic pf_s1_ff;
    logic pf_s2_ff;
    logic saving_ff;
    // walk pointer kept apart so the index shown always matches the data beside it
    logic [IW-1:0] walk_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            walk_ff <= '0;
            pf_s1_ff <= 1'b0;
            pf_s2_ff <= 1'b0;
            saving_ff <= 1'b0;
            save_index <= '0;
            save_valid <= 1'b0;
            save_count <= '0;
            save_frozen <= '0;
            save_done <= 1'b0;
        end else begin
            pf_s1_ff <= power_fail;
            pf_s2_ff <= pf_s1_ff;
            save_valid <= 1'b0;
            if (pf_s2_ff && !saving_ff && !save_done) begin
                saving_ff <= 1'b1;
                walk_ff <= '0;
            end else if (saving_ff) begin
                save_valid <= 1'b1;
                save_index <= walk_ff;
                save_count <= count_ff[walk_ff];
                save_frozen <= frozen_ff[walk_ff];
                if (walk_ff == IW'(N-1)) begin
                    saving_ff <= 1'b0;
                    save_done <= 1'b1;
                end else begin
                    walk_ff <= walk_ff + 1'b1;
                end
            end
        end
    end
endmodule // udcb_bank
`default_nettype wire

/* test/udcb_assertions.sv */
// checker for the port behaviour of the counter bank
`timescale 1ns/1ps
`default_nettype none
module udcb_assertions
    import udcb_pkg::*;
#(
    parameter int unsigned N = UDCB_NUM_COUNTERS
) (
    // clock, reset and register port
    input wire logic clk,
    input wire logic reset,
    input wire logic [UDCB_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // operands and stamp
    input wire udcb_ops_t ops [N],
    input wire logic [UDCB_STAMP_W-1:0] time_stamp,
    // save stream and flags
    input wire logic power_fail,
    input wire logic save_valid,
    input wire logic [$clog2(N)-1:0] save_index,
    input wire logic [31:0] save_count,
    input wire logic [31:0] save_frozen,
    input wire logic save_done,
    input wire udcb_flags_t flags [N]
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // power loss must be seen through the two-stage synchroniser first
    sequence fail_held_s; $rose(power_fail) ##1 power_fail [*2]; endsequence
    sequence block_held_s; (ops[0].block && !reg_wr) [*6]; endsequence
    save_start_a: assert property (fail_held_s ##0 !save_done |-> ##[0:6] save_valid)
        else $error("save stream did not start after power loss");
    save_first_a: assert property ($rose(save_valid) && !save_done |-> save_index == 0)
        else $error("save stream did not open with counter zero");
    save_last_a: assert property (save_valid && save_index == N-1 |-> ##[0:1] save_done)
        else $error("save done missing after last counter");
    save_sticky_a: assert property (save_done |=> save_done)
        else $error("save done dropped");
    flags_onehot_a: assert property (!$past(reset) |-> $onehot(flags[0]) && $onehot(flags[N-1]))
        else $error("compare flags not exclusive");
    block_hold_a: assert property (block_held_s |-> $stable(flags[0]))
        else $error("flags moved while blocked");
    unmapped_read_a: assert property (reg_rd && reg_addr[7:4] >= N |=> reg_rdata == 32'h0)
        else $error("unmapped counter read not zero");
    read_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the answer cycle");
endmodule // udcb_assertions
bind udcb_bank udcb_assertions #(.N(N)) i_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ops(ops),
    .time_stamp(time_stamp), .power_fail(power_fail), .save_valid(save_valid),
    .save_index(save_index), .save_count(save_count), .save_frozen(save_frozen),
    .save_done(save_done), .flags(flags));
`default_nettype wire

/* test/udcb_ops_model.sv */
// operand source model: follows requested levels, each held three cycles
`timescale 1ns/1ps
`default_nettype none
module udcb_ops_model
    import udcb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // requested and driven levels
    input wire udcb_ops_t req,
    output udcb_ops_t ops
);
    udcb_ops_t ops_ff;
    logic [1:0] hold_ff;
    // short levels would be lost by the sampler, so each change is held
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ops_ff <= '0;
            hold_ff <= 2'h0;
        end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
        end else if (req != ops_ff) begin
            ops_ff <= req;
            hold_ff <= 2'h2;
        end
    end
    assign ops = ops_ff;
endmodule // udcb_ops_model
`default_nettype wire

/* test/udcb_bank_tb.sv */
// self-checking bench for the counter bank
`timescale 1ns/1ps
`default_nettype none
module udcb_bank_tb;
    import udcb_pkg::*;
    logic clk, reset, reg_wr, reg_rd, power_fail, save_valid, save_done, rd_q;
    logic [UDCB_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, save_count, save_frozen, p;
    logic [UDCB_STAMP_W-1:0] time_stamp;
    logic [2:0] save_index;
    logic [6:0] b;
    udcb_ops_t req [8], ops [8];
    udcb_flags_t flags [8];
    logic [31:0] ec [8];
    logic [31:0] expq [$];
    int num_errors = 0, checks_done = 0, seed = 10766, k;
    udcb_bank #(.N(8)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ops(ops), .time_stamp(time_stamp),
        .power_fail(power_fail), .save_valid(save_valid), .save_index(save_index),
        .save_count(save_count), .save_frozen(save_frozen), .save_done(save_done), .flags(flags));
    // one operand source per counter
    for (genvar g = 0; g < 8; g++) begin : g_src
        udcb_ops_model i_src (.clk(clk), .reset(reset), .req(req[g]), .ops(ops[g]));
    end
    task automatic close_out();
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // a gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input int i, input logic [3:0] off, input logic [31:0] d);
        reg_addr <= {i[3:0], off};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input int i, input logic [3:0] off, input logic [31:0] e);
        expq.push_back(e);
        reg_addr <= {i[3:0], off};
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    // six cycles cover model hold, sampler delay and flag update
    task automatic setop(input int i, input logic [6:0] v);
        req[i] <= udcb_ops_t'(v);
        repeat (6) @(posedge clk);
    endtask
    task automatic pulse(input int i, input logic [6:0] base, input logic [6:0] v);
        setop(i, base | v);
        setop(i, base);
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clk) rd_q <= reg_rd;
    always @(negedge clk) begin
        if (rd_q === 1'b1) begin
            if (expq.size() == 0) chk("unexpected read", 32'h0, 32'hffffffff);
            else chk("read data", expq.pop_front(), reg_rdata);
        end
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(100 * 50000);
        num_errors++;
        close_out();
    end
    initial begin
        {reset, reg_wr, reg_rd, power_fail} = 4'b1000;
        reg_addr = '0;
        reg_wdata = '0;
        time_stamp = {$random(seed), $random(seed)};
        for (k = 0; k < 8; k++) req[k] = '0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(0, UDCB_REG_PRESET, UDCB_PRESET_RST);
        rd(0, UDCB_REG_FLAGS, 32'h2);
        rd(0, 4'h9, UDCB_RDATA_UNMAPPED);
        rd(8, UDCB_REG_COUNT, UDCB_RDATA_UNMAPPED);
        // every counter: load on enable, single count per rise, cancel
        for (k = 0; k < 8; k++) begin
            p = $random(seed);
            b = k[0] ? 7'h00 : 7'h08;
            ec[k] = k[0] ? 32'h0 : p;
            wr(k, UDCB_REG_PRESET, p);
            setop(k, b);
            wr(k, UDCB_REG_CTRL, 32'h1);
            rd(k, UDCB_REG_COUNT, ec[k]);
            pulse(k, b, 7'h40);
            rd(k, UDCB_REG_COUNT, ec[k] + 32'h1);
            pulse(k, b, 7'h20);
            pulse(k, b, 7'h60);
            rd(k, UDCB_REG_COUNT, ec[k]);
        end
        // signed limits, select edges, signed compare
        setop(0, 7'h00);
        rd(0, UDCB_REG_COUNT, ec[0]);
        wr(0, UDCB_REG_PRESET, 32'h7fffffff);
        wr(0, UDCB_REG_COMPARE, 32'hffffffff);
        setop(0, 7'h08);
        rd(0, UDCB_REG_COUNT, 32'h7fffffff);
        rd(0, UDCB_REG_FLAGS, 32'h1);
        pulse(0, 7'h08, 7'h40);
        rd(0, UDCB_REG_COUNT, 32'h80000000);
        rd(0, UDCB_REG_FLAGS, 32'h4);
        pulse(0, 7'h08, 7'h20);
        rd(0, UDCB_REG_COUNT, 32'h7fffffff);
        pulse(0, 7'h18, 7'h44);
        rd(0, UDCB_REG_COUNT, 32'h7fffffff);
        // freezes capture count and stamp
        pulse(0, 7'h08, 7'h01);
        rd(0, UDCB_REG_FROZEN, 32'h7fffffff);
        rd(0, UDCB_REG_STAMP_LO, time_stamp[31:0]);
        rd(0, UDCB_REG_STAMP_HI, time_stamp[63:32]);
        pulse(0, 7'h08, 7'h40);
        rd(0, UDCB_REG_COUNT, 32'h80000000);
        pulse(0, 7'h08, 7'h04);
        rd(0, UDCB_REG_COUNT, 32'h7fffffff);
        setop(0, 7'h00);
        pulse(0, 7'h00, 7'h02);
        rd(0, UDCB_REG_FROZEN, 32'h7fffffff);
        rd(0, UDCB_REG_COUNT, UDCB_COUNT_ZERO);
        wr(1, UDCB_REG_CTRL, 32'h0);
        pulse(1, 7'h00, 7'h40);
        rd(1, UDCB_REG_COUNT, ec[1]);
        // power loss streams every counter out
        power_fail <= 1'b1;
        k = 0;
        repeat (40) begin
            @(negedge clk);
            if (save_valid === 1'b1) k++;
            if (save_valid === 1'b1 && save_index === 3'h2) chk("saved", ec[2], save_count);
        end
        chk("save pulses", 32'd8, k);
        chk("save done", 32'h1, {31'h0, save_done});
        close_out();
    end
endmodule // udcb_bank_tb
`default_nettype wire
